// ---- src/icr_regs.svh ----
// Register offsets, bit positions, reset values and fixed constants
// of the core interrupt control block.
// Assumes a byte-addressed 32-bit Avalon-MM register port.
`ifndef ICR_REGS_SVH
`define ICR_REGS_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define ICR_ADDR_W 4
`define ICR_OFS_IRQ_CONTROL 4'h0
`define ICR_OFS_EDGE_CONFIG 4'h4
`define ICR_OFS_PIN_CHANGE 4'h8

// ****************************************************************
// Bit positions of irq_control
// ****************************************************************
`define ICR_BIT_GLOBAL_EN 7
`define ICR_BIT_PERIPH_EN 6
`define ICR_BIT_TMR0_EN 5
`define ICR_BIT_EXT_EN 4
`define ICR_BIT_PCHG_EN 3
`define ICR_BIT_TMR0_FLAG 2
`define ICR_BIT_EXT_FLAG 1
`define ICR_BIT_PCHG_FLAG 0

// Bit position of ext_pin_edge_select in the edge configuration register
`define ICR_BIT_EDGE_SEL 0

// ****************************************************************
// Reset values and fixed constants
// ****************************************************************
`define ICR_RST_IRQ_CONTROL 8'h00
`define ICR_RST_EDGE_CONFIG 1'h0
`define ICR_RST_RDATA 32'h0000_0000
`define ICR_IRQ_VECTOR 16'h0004
`define ICR_VECTOR_RST 16'h0000

`endif

// ---- src/icr_pkg.sv ----
// Types shared by the core interrupt control block.
// Assumes icr_regs.svh supplies the numeric constants.
package icr_pkg;

    // ****************************************************************
    // Interrupt control register layout, bit 7 first
    // ****************************************************************
    typedef struct packed {
        logic global_irq_enable;
        logic periph_irq_enable;
        logic timer0_overflow_irq_enable;
        logic ext_pin_irq_enable;
        logic pin_change_irq_enable;
        logic timer0_overflow_flag;
        logic ext_pin_flag;
        logic pin_change_summary_flag;
    } icr_ctrl_t;

    // Hardware events seen in one cycle
    typedef struct packed {
        logic timer0_overflow;
        logic ext_pin_edge;
        logic irq_taken;
        logic return_from_irq;
    } icr_event_t;

    // Register port handshake states
    typedef enum logic [0:0] {
        ICR_BUS_IDLE,
        ICR_BUS_ACK
    } icr_bus_state_t;

endpackage : icr_pkg

// ---- src/icr_edge_sync.sv ----
// Two-stage synchroniser with rising and falling edge pulses.
// Assumes the input is asynchronous to core_clk and held for at
// least two clock periods per level.
`timescale 1ns/1ps
`include "icr_regs.svh"

module icr_edge_sync
    import icr_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Asynchronous level in
    input wire logic async_in,
    // Edge pulses out
    output logic rise_pulse,
    output logic fall_pulse
);

    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            meta_reg <= 1'h0;
            sync_reg <= 1'h0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    // History stage for edge detection
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            last_reg <= 1'h0;
        else
            last_reg <= sync_reg;
    end

    // Edge pulses from the synchronised level
    assign rise_pulse = sync_reg & ~last_reg;
    assign fall_pulse = ~sync_reg & last_reg;

endmodule : icr_edge_sync

// ---- src/icr_core.sv ----
// Core interrupt control register with its request logic.
// Assumes the timer, pin-change and peripheral sources run on core_clk,
// the external interrupt pin is asynchronous, and the core pulses
// irq_taken when it vectors and return_from_irq when it leaves service.
//
// How it works
// - Flags set on their source event regardless of any enable bit.
// - ext_pin_flag at bit 1 reads one after a qualifying pin edge.
// - Bit 0 reads one while any pin-change flag was set the cycle before.
// - Summary flag ignores writes, clears with all pin-change flags, resets zero.
// - Global enable low blocks vectoring; latched flags are serviced later.
// - Taking an interrupt clears global enable, vectors to 0004h; return sets it.
// - Pin flag sets on rising edge if edge select one, else falling.
//
// Implementation choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`include "icr_regs.svh"

module icr_core
    import icr_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Avalon-MM register slave
    input wire logic [`ICR_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Interrupt sources
    input wire logic timer0_overflow,
    input wire logic ext_irq_pin,
    input wire logic [7:0] pin_change_flags_b,
    input wire logic periph_irq_pending,
    // Processor core handshake
    input wire logic irq_taken,
    input wire logic return_from_irq,
    output logic irq_request,
    output logic [15:0] irq_vector
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    // Register state and events of the cycle
    icr_ctrl_t ctrl_reg;
    icr_event_t evt;
    // Bus handshake and read path
    icr_bus_state_t bus_state_reg;
    icr_bus_state_t bus_state_next;
    logic edge_select_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [15:0] vector_reg;
    // Synchronised pin edges
    logic pin_rise;
    logic pin_fall;
    // Write decode
    logic write_commit;
    logic ctrl_write;
    logic edge_write;
    logic [7:0] wbyte;
    logic pin_change_any;

    // Read view of the irq_control, edge configuration and pin-change registers for a decoded offset
    function automatic logic [31:0] read_mux(
        input logic [`ICR_ADDR_W-1:0] addr,
        input icr_ctrl_t ctrl,
        input logic edge_sel,
        input logic [7:0] pchg
    );
        logic [31:0] val;
        val = `ICR_RST_RDATA;
        unique case (addr)
            `ICR_OFS_IRQ_CONTROL: val[7:0] = ctrl;
            `ICR_OFS_EDGE_CONFIG: val[`ICR_BIT_EDGE_SEL] = edge_sel;
            `ICR_OFS_PIN_CHANGE: val[7:0] = pchg;
            default: val = `ICR_RST_RDATA;
        endcase
        return val;
    endfunction : read_mux

    // A hardware set beats a software clear in the same cycle, so an event
    // that lands on the clearing write is never lost
    // Next value of a software-written flag: a set from hardware wins
    function automatic logic flag_next(
        input logic cur,
        input logic set,
        input logic wr,
        input logic wval
    );
        logic res;
        res = cur;
        if (wr)
            res = wval;
        if (set)
            res = 1'h1;
        return res;
    endfunction : flag_next

    // Reset value of one irq_control bit, picked from the whole-register constant
    function automatic logic rst_bit(
        input int unsigned pos
    );
        logic [7:0] rst_val;
        rst_val = `ICR_RST_IRQ_CONTROL;
        return rst_val[pos[2:0]];
    endfunction : rst_bit

    // Address decode shared by the write strobes
    function automatic logic addr_hit(
        input logic [`ICR_ADDR_W-1:0] addr,
        input logic [`ICR_ADDR_W-1:0] ofs
    );
        return addr == ofs;
    endfunction : addr_hit

    // ****************************************************************
    // External pin synchroniser and edge detection
    // ****************************************************************
    // The pin is asynchronous; two flops guard against metastability
    // before any edge logic looks at it
    icr_edge_sync u_pin_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .async_in(ext_irq_pin),
        .rise_pulse(pin_rise),
        .fall_pulse(pin_fall)
    );

    // Qualifying edge chosen by the edge select bit
    assign evt.ext_pin_edge = edge_select_reg ? pin_rise : pin_fall;
    assign evt.timer0_overflow = timer0_overflow;
    assign evt.irq_taken = irq_taken;
    assign evt.return_from_irq = return_from_irq;

    // Summary of the individual pin-change flags
    assign pin_change_any = |pin_change_flags_b;

    // ****************************************************************
    // Avalon-MM slave handshake
    // ****************************************************************

    // One wait cycle, then the acknowledge cycle
    always_comb
    begin
        bus_state_next = bus_state_reg;
        unique case (bus_state_reg)
            ICR_BUS_IDLE:
                if (avs_read || avs_write)
                    bus_state_next = ICR_BUS_ACK;
            ICR_BUS_ACK:
                bus_state_next = ICR_BUS_IDLE;
        endcase
    end

    // Handshake state register
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            bus_state_reg <= ICR_BUS_IDLE;
        else
            bus_state_reg <= bus_state_next;
    end

    // Waitrequest drops only in the acknowledge cycle
    assign avs_waitrequest = (bus_state_reg != ICR_BUS_ACK);

    // Write takes effect at the edge ending the acknowledge cycle.
    // Only that cycle commits, so a request held through its wait state
    // lands exactly once.
    assign write_commit = (bus_state_reg == ICR_BUS_ACK) && avs_write && avs_byteenable[0];
    assign ctrl_write = write_commit && addr_hit(avs_address, `ICR_OFS_IRQ_CONTROL);
    assign edge_write = write_commit && addr_hit(avs_address, `ICR_OFS_EDGE_CONFIG);
    assign wbyte = avs_writedata[7:0];

    // Read data captured when the request is first seen, so they stand
    // unchanged through the acknowledge cycle that follows
    always_comb
    begin
        rdata_next = rdata_reg;
        if ((bus_state_reg == ICR_BUS_IDLE) && avs_read)
            rdata_next = read_mux(avs_address, ctrl_reg, edge_select_reg, pin_change_flags_b);
    end

    // Read data register, held through the acknowledge cycle
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            rdata_reg <= `ICR_RST_RDATA;
        else
            rdata_reg <= rdata_next;
    end

    assign avs_readdata = rdata_reg;

    // ****************************************************************
    // Edge configuration register
    // ****************************************************************

    // Edge select written by software
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            edge_select_reg <= `ICR_RST_EDGE_CONFIG;
        else if (edge_write)
            edge_select_reg <= avs_writedata[`ICR_BIT_EDGE_SEL];
    end

    // ****************************************************************
    // Interrupt control register
    // ****************************************************************

    // Global enable: taking an interrupt clears it, returning sets it.
    // Core events outrank a software write of the same cycle, so a write
    // racing a take cannot reopen the core to a second request.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            ctrl_reg.global_irq_enable <= rst_bit(`ICR_BIT_GLOBAL_EN);
        else if (evt.irq_taken)
            ctrl_reg.global_irq_enable <= 1'h0;
        else if (evt.return_from_irq)
            ctrl_reg.global_irq_enable <= 1'h1;
        else if (ctrl_write)
            ctrl_reg.global_irq_enable <= wbyte[`ICR_BIT_GLOBAL_EN];
    end

    // Plain enable bits written by software
    // Software is expected to clear stale flags before raising these
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ctrl_reg.periph_irq_enable <= rst_bit(`ICR_BIT_PERIPH_EN);
            ctrl_reg.timer0_overflow_irq_enable <= rst_bit(`ICR_BIT_TMR0_EN);
            ctrl_reg.ext_pin_irq_enable <= rst_bit(`ICR_BIT_EXT_EN);
            ctrl_reg.pin_change_irq_enable <= rst_bit(`ICR_BIT_PCHG_EN);
        end
        else if (ctrl_write)
        begin
            ctrl_reg.periph_irq_enable <= wbyte[`ICR_BIT_PERIPH_EN];
            ctrl_reg.timer0_overflow_irq_enable <= wbyte[`ICR_BIT_TMR0_EN];
            ctrl_reg.ext_pin_irq_enable <= wbyte[`ICR_BIT_EXT_EN];
            ctrl_reg.pin_change_irq_enable <= wbyte[`ICR_BIT_PCHG_EN];
        end
    end

    // Timer0 overflow flag, set regardless of any enable
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            ctrl_reg.timer0_overflow_flag <= rst_bit(`ICR_BIT_TMR0_FLAG);
        else
            ctrl_reg.timer0_overflow_flag <= flag_next(ctrl_reg.timer0_overflow_flag,
                evt.timer0_overflow, ctrl_write, wbyte[`ICR_BIT_TMR0_FLAG]);
    end

    // External pin flag, set by the selected edge regardless of any enable
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            ctrl_reg.ext_pin_flag <= rst_bit(`ICR_BIT_EXT_FLAG);
        else
            ctrl_reg.ext_pin_flag <= flag_next(ctrl_reg.ext_pin_flag,
                evt.ext_pin_edge, ctrl_write, wbyte[`ICR_BIT_EXT_FLAG]);
    end

    // Summary flag follows the pin-change flags and ignores writes.
    // It runs one cycle behind them; software clears it only by clearing
    // every individual pin-change flag.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            ctrl_reg.pin_change_summary_flag <= rst_bit(`ICR_BIT_PCHG_FLAG);
        else
            ctrl_reg.pin_change_summary_flag <= pin_change_any;
    end

    // ****************************************************************
    // Core request and vector
    // ****************************************************************

    // Request only while global enable is high; flags stay latched meanwhile
    // Combinational, so the core sees the request the cycle a flag shows
    assign irq_request = ctrl_reg.global_irq_enable && (
        (ctrl_reg.timer0_overflow_irq_enable && ctrl_reg.timer0_overflow_flag) ||
        (ctrl_reg.ext_pin_irq_enable && ctrl_reg.ext_pin_flag) ||
        (ctrl_reg.pin_change_irq_enable && ctrl_reg.pin_change_summary_flag) ||
        (ctrl_reg.periph_irq_enable && periph_irq_pending));

    // Vector address, fixed once out of reset
    // Held at zero in reset so a core sampling early sees no vector
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            vector_reg <= `ICR_VECTOR_RST;
        else
            vector_reg <= `ICR_IRQ_VECTOR;
    end

    assign irq_vector = vector_reg;

endmodule : icr_core

// ---- verification/icr_core_assertions.sv ----
// Port checker for the interrupt control block.
// Assumes it is bound to icr_core, one clock, synchronous reset.
`timescale 1ns/1ps
`include "icr_regs.svh"

module icr_core_assertions (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Register bus
    input wire logic [`ICR_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Sources and core
    input wire logic timer0_overflow,
    input wire logic [7:0] pin_change_flags_b,
    input wire logic irq_taken,
    input wire logic return_from_irq,
    input wire logic irq_request,
    input wire logic [15:0] irq_vector
);
    // ****
    // Properties
    // ****
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered after one wait");
    a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("bus acknowledge longer than one cycle");
    a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> !irq_request
        && avs_waitrequest && avs_readdata == 32'h0 && irq_vector == 16'h0)
        else $error("outputs not quiet in reset");
    a_vector_fixed: assert property (!sys_rst |=> irq_vector == `ICR_IRQ_VECTOR)
        else $error("vector not 0004");
    a_taken_drops: assert property (irq_taken |=> !irq_request)
        else $error("request stays after interrupt taken");
    a_global_held_low: assert property (irq_taken ##1 !(return_from_irq || avs_write)
        |=> !irq_request) else $error("request while global enable low");
    a_timer_flag_set: assert property (timer0_overflow ##1 !avs_write ##1
        (avs_read && avs_waitrequest && avs_address == 4'h0) |=> avs_readdata[2])
        else $error("timer flag not set by overflow");
    a_pchg_summary: assert property (avs_read && avs_waitrequest
        && avs_address == 4'h0 && !$past(sys_rst)
        |=> avs_readdata[0] == $past(|pin_change_flags_b, 2))
        else $error("summary flag differs from pin change flags");
endmodule : icr_core_assertions

bind icr_core icr_core_assertions chk (.core_clk, .sys_rst, .avs_address, .avs_read,
    .avs_write, .avs_readdata, .avs_waitrequest, .timer0_overflow, .pin_change_flags_b,
    .irq_taken, .return_from_irq, .irq_request, .irq_vector);

// ---- verification/icr_core_model.sv ----
// Processor core model facing the interrupt control block.
// Assumes the bench shares the clock and chooses when it takes and returns.
`timescale 1ns/1ps

module icr_core_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Bench controls
    input wire logic auto_take,
    input wire logic ret_cmd,
    // Interrupt handshake
    input wire logic irq_request,
    input wire logic [15:0] irq_vector,
    output logic irq_taken,
    output logic return_from_irq,
    output logic [15:0] vector_seen
);
    // Takes a pending request with one-cycle pulses; never takes while auto_take is held low
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            irq_taken <= 1'b0;
            return_from_irq <= 1'b0;
            vector_seen <= 16'h0;
        end
        else
        begin
            irq_taken <= auto_take && irq_request && !irq_taken;
            return_from_irq <= ret_cmd && !return_from_irq;
            if (auto_take && irq_request)
                vector_seen <= irq_vector;
        end
    end
endmodule : icr_core_model

// ---- verification/core_irq_control_register_bench.sv ----
// Self-checking bench for the interrupt control block.
// Assumes icr_core, the core model and the bound checker.
`timescale 1ns/1ps
`include "icr_regs.svh"

module core_irq_control_register_bench;
    import icr_pkg::*;
    `define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_errors++; \
        $display("mismatch at %0t got %h expected %h", $time, got, exp); end end

    logic core_clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic timer0_overflow = 1'b0, ext_irq_pin = 1'b0, periph_irq_pending = 1'b0;
    logic [7:0] pin_change_flags_b = 8'h00;
    logic avs_waitrequest, irq_taken, return_from_irq, irq_request;
    logic auto_take = 1'b0, ret_cmd = 1'b0;
    logic [15:0] irq_vector, vector_seen;
    int n_errors = 0, cmp_count = 0, cyc = 0;

    icr_core DUT (.core_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .timer0_overflow, .ext_irq_pin,
        .pin_change_flags_b, .periph_irq_pending, .irq_taken, .return_from_irq,
        .irq_request, .irq_vector);
    icr_core_model core_model (.core_clk, .sys_rst, .auto_take, .ret_cmd, .irq_request,
        .irq_vector, .irq_taken, .return_from_irq, .vector_seen);

    // ****
    // Clock, timeout and tasks
    // ****
    initial
    begin
        forever #10 core_clk = ~core_clk;
    end

    // Cuts a hang short
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_errors++;
            wrap_up();
        end
    end

    task wrap_up;
        if (n_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up

    task tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick

    // One bus transfer, held until waitrequest is seen low
    task bus(input logic is_wr, input logic [3:0] a, input logic [7:0] d,
        output logic [31:0] q);
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= is_wr;
        avs_read <= !is_wr;
        avs_writedata <= {24'h0, d};
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task rd_chk(input logic [3:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        `CHK(q, {24'h0, e})
    endtask : rd_chk

    task pulse_timer;
        @(posedge core_clk) timer0_overflow <= 1'b1;
        @(posedge core_clk) timer0_overflow <= 1'b0;
    endtask : pulse_timer

    // ****
    // Main sequence
    // ****
    initial
    begin
        tick(2);
        sys_rst <= 1'b0;
        rd_chk(`ICR_OFS_IRQ_CONTROL, 8'h00);
        rd_chk(`ICR_OFS_EDGE_CONFIG, 8'h00);
        wr(4'h0, 8'hff);
        rd_chk(4'h0, 8'hfe);
        `CHK(irq_request, 1'b1)
        wr(4'h0, 8'h00);
        avs_byteenable <= 4'he;
        wr(4'h0, 8'h80);
        avs_byteenable <= 4'hf;
        rd_chk(4'h0, 8'h00);
        rd_chk(4'hc, 8'h00);
        wr(4'h8, 8'hff);
        rd_chk(4'h8, 8'h00);
        pulse_timer;
        rd_chk(4'h0, 8'h04);
        `CHK(irq_request, 1'b0)
        wr(4'h0, 8'h00);
        // Wrong edge then chosen edge, for both selections
        for (int s = 0; s < 2; s++)
        begin
            wr(4'h4, 8'(s));
            rd_chk(4'h4, 8'(s));
            for (int k = 0; k < 3; k++)
            begin
                @(posedge core_clk) ext_irq_pin <= (k == 1) ? !s[0] : s[0];
                tick(5);
                if (k == 0)
                    wr(4'h0, 8'h00);
                else
                    rd_chk(4'h0, (k == 2) ? 8'h02 : 8'h00);
            end
        end
        wr(4'h0, 8'h00);
        @(posedge core_clk) pin_change_flags_b <= 8'h10;
        tick(2);
        rd_chk(4'h0, 8'h01);
        rd_chk(4'h8, 8'h10);
        wr(4'h0, 8'h88);
        tick(1);
        `CHK(irq_request, 1'b1)
        rd_chk(4'h0, 8'h89);
        @(posedge core_clk) pin_change_flags_b <= 8'h00;
        tick(2);
        rd_chk(4'h0, 8'h88);
        `CHK(irq_request, 1'b0)
        @(posedge core_clk) periph_irq_pending <= 1'b1;
        wr(4'h0, 8'h80);
        tick(1);
        `CHK(irq_request, 1'b0)
        wr(4'h0, 8'hc0);
        tick(1);
        `CHK(irq_request, 1'b1)
        wr(4'h0, 8'h00);
        @(posedge core_clk) periph_irq_pending <= 1'b0;
        // Timer interrupt taken by the core, then returned
        wr(4'h0, 8'h20);
        pulse_timer;
        tick(1);
        `CHK(irq_request, 1'b0)
        rd_chk(4'h0, 8'h24);
        wr(4'h0, 8'ha4);
        tick(1);
        `CHK(irq_request, 1'b1)
        `CHK(irq_vector, 16'h0004)
        @(posedge core_clk) auto_take <= 1'b1;
        tick(3);
        `CHK(vector_seen, 16'h0004)
        rd_chk(4'h0, 8'h24);
        wr(4'h0, 8'h20);
        @(posedge core_clk) auto_take <= 1'b0;
        ret_cmd <= 1'b1;
        @(posedge core_clk) ret_cmd <= 1'b0;
        tick(3);
        rd_chk(4'h0, 8'ha0);
        wrap_up();
    end
endmodule : core_irq_control_register_bench
